// ===== rtl/dcpf_params.svh
// constants of the programmable fifo controller
`ifndef DCPF_PARAMS_SVH
`define DCPF_PARAMS_SVH
// ----------------------------------------------------------------
// storage geometry
// ----------------------------------------------------------------
`define DCPF_DW 36
`define DCPF_CW 8
`define DCPF_AW 4
`define DCPF_PW 5
`define DCPF_DEPTH 16
`define DCPF_DEPTH9 9'h010
`define DCPF_AE_RST 8'h02
`define DCPF_AF_RST 8'h02
// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define DCPF_AXI_AW 8
`define DCPF_STS_OFS 8'h00
`define DCPF_EN_OFS 8'h04
`define DCPF_CLR_OFS 8'h08
`define DCPF_LVL_OFS 8'h0C
`define DCPF_AE_OFS 8'h10
`define DCPF_AF_OFS 8'h14
// ----------------------------------------------------------------
// event bits and level register fields
// ----------------------------------------------------------------
`define DCPF_EV_W 4
`define DCPF_EV_FULL 0
`define DCPF_EV_EMPTY 1
`define DCPF_EV_OVF 2
`define DCPF_EV_UDF 3
`define DCPF_LVL_EMPTY 8
`define DCPF_LVL_FULL 9
`define DCPF_LVL_AE 10
`define DCPF_LVL_AF 11
`define DCPF_RESP_OKAY 2'h0
`define DCPF_RESP_SLVERR 2'h2
`endif

// ===== rtl/dcpf_pkg.sv
// types of the programmable fifo controller
`include "dcpf_params.svh"
package dcpf_pkg;
  typedef logic [`DCPF_DEPTH-1:0][`DCPF_DW-1:0] dcpf_mem_t;

  typedef struct packed {
    dcpf_mem_t mem;
    logic [`DCPF_PW-1:0] wptr;
    logic [`DCPF_PW-1:0] rptr;
    logic [`DCPF_PW-1:0] mark;
    logic [`DCPF_DW-1:0] dout;
    logic emptyN;
    logic fullN;
    logic aeN;
    logic afN;
    logic [`DCPF_CW-1:0] aeOff;
    logic [`DCPF_CW-1:0] afOff;
    logic cfgWIdx;
    logic cfgRIdx;
    logic sclkPrev;
    logic [`DCPF_EV_W-1:0] sts;
    logic [`DCPF_EV_W-1:0] irqEn;
    logic irq;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } dcpf_state_s;
endpackage : dcpf_pkg

// ===== rtl/dcpf_fifo_ctrl.sv
// programmable fifo controller with mark, retransmit and serial load
//
// Summary of operation
// - write strobe stores word to memory, or to offsets when load select low
// - read strobe fetches next memory word, or offsets when load select low
// - offset accesses use only the low eight data lines
// - memory accesses use the full 36-bit data buses
// - empty flag low while memory holds nothing, updated on the clock
// - full flag low while memory is full, updated on the clock
// - almost-empty flag low when level reaches almost-empty offset
// - almost-full flag low when free space falls to almost-full offset
// - retransmit reloads read pointer with the marked location
// - after retransmit, reads replay old data until pointers meet
// - master reset clears pointers and output register
// - master reset restores offsets to defaults and resets flags
// - partial reset clears pointers and output register
// - partial reset keeps offsets, still resets flags
// - serial clock rising edge with load enable shifts bit into offsets
// - mark records the current read pointer as retransmit target
// - enabled write advances pointer unless full, even with input drive off; skipped slot unwritten
`timescale 1ns/1ps
`include "dcpf_params.svh"
module dcpf_fifo_ctrl
  import dcpf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic writeEn,
  input wire logic loadSelectN,
  input wire logic inputDriveEnable,
  input wire logic [`DCPF_DW-1:0] dataIn,
  input wire logic readEn,
  output logic [`DCPF_DW-1:0] dataOut,
  output logic emptyFlagN,
  output logic fullFlagN,
  output logic almostEmptyFlagN,
  output logic almostFullFlagN,
  input wire logic markReq,
  input wire logic retransmitReq,
  input wire logic masterResetN,
  input wire logic partialResetN,
  input wire logic serialClk,
  input wire logic serialLoadEnable,
  input wire logic serialIn,
  input wire logic [`DCPF_AXI_AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`DCPF_AXI_AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  localparam dcpf_state_s RST_S = '{
    fullN: 1'b1,
    afN: 1'b1,
    sclkPrev: 1'b1, // an idle-high serial clock must not look like an edge
    aeOff: `DCPF_AE_RST,
    afOff: `DCPF_AF_RST,
    default: '0
  };

  dcpf_state_s q;
  dcpf_state_s d;
  logic wrGo;
  logic rdGo;
  logic sEdge;
  logic awGo;
  logic arGo;
  logic [`DCPF_CW-1:0] lvl;
  logic [`DCPF_CW-1:0] lvlNow;
  logic [`DCPF_EV_W-1:0] ev;
  logic [`DCPF_EV_W-1:0] clr;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    wrGo = writeEn && loadSelectN && q.fullN;
    rdGo = readEn && loadSelectN && q.emptyN;
    sEdge = serialClk && !q.sclkPrev && serialLoadEnable;
    awGo = awvalid && wvalid && !q.awready && !q.bvalid;
    arGo = arvalid && !q.arready && !q.rvalid;
    lvlNow = {3'h0, q.wptr - q.rptr};
    d.sclkPrev = serialClk;
    // bus write: accept address and data together, answer next cycle
    if (q.bvalid && bready) begin
      d.bvalid = 1'b0;
    end
    if (awGo) begin
      d.awready = 1'b1;
      d.wready = 1'b1;
    end
    if (q.awready) begin
      d.awready = 1'b0;
      d.wready = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = `DCPF_RESP_OKAY;
      case (awaddr)
        `DCPF_EN_OFS: begin
          if (wstrb[0]) d.irqEn = wdata[`DCPF_EV_W-1:0];
        end
        `DCPF_CLR_OFS: begin
          if (wstrb[0]) clr = wdata[`DCPF_EV_W-1:0];
        end
        `DCPF_AE_OFS: begin
          if (wstrb[0]) d.aeOff = wdata[`DCPF_CW-1:0];
        end
        `DCPF_AF_OFS: begin
          if (wstrb[0]) d.afOff = wdata[`DCPF_CW-1:0];
        end
        default: begin
          d.bresp = `DCPF_RESP_SLVERR;
        end
      endcase
    end
    // bus read
    if (q.rvalid && rready) begin
      d.rvalid = 1'b0;
    end
    if (arGo) begin
      d.arready = 1'b1;
    end
    if (q.arready) begin
      d.arready = 1'b0;
      d.rvalid = 1'b1;
      d.rresp = `DCPF_RESP_OKAY;
      d.rdata = '0;
      case (araddr)
        `DCPF_STS_OFS: d.rdata[`DCPF_EV_W-1:0] = q.sts;
        `DCPF_EN_OFS: d.rdata[`DCPF_EV_W-1:0] = q.irqEn;
        `DCPF_CLR_OFS: d.rdata = '0;
        `DCPF_LVL_OFS: begin
          d.rdata[`DCPF_CW-1:0] = lvlNow;
          d.rdata[`DCPF_LVL_EMPTY] = q.emptyN;
          d.rdata[`DCPF_LVL_FULL] = q.fullN;
          d.rdata[`DCPF_LVL_AE] = q.aeN;
          d.rdata[`DCPF_LVL_AF] = q.afN;
        end
        `DCPF_AE_OFS: d.rdata[`DCPF_CW-1:0] = q.aeOff;
        `DCPF_AF_OFS: d.rdata[`DCPF_CW-1:0] = q.afOff;
        default: d.rresp = `DCPF_RESP_SLVERR;
      endcase
    end
    // serial path: one chain, almost-full offset nearest the input
    if (sEdge) begin
      {d.aeOff, d.afOff} = {q.aeOff[`DCPF_CW-2:0], q.afOff, serialIn};
    end
    // parallel offset load alternates between the two offsets
    if (writeEn && !loadSelectN) begin
      if (q.cfgWIdx) begin
        d.afOff = dataIn[`DCPF_CW-1:0];
      end else begin
        d.aeOff = dataIn[`DCPF_CW-1:0];
      end
      d.cfgWIdx = !q.cfgWIdx;
    end
    if (wrGo) begin
      if (inputDriveEnable) begin
        d.mem[q.wptr[`DCPF_AW-1:0]] = dataIn;
      end
      d.wptr = q.wptr + 1'b1;
    end
    if (writeEn && loadSelectN && !q.fullN) begin
      ev[`DCPF_EV_OVF] = 1'b1;
    end
    if (readEn && !loadSelectN) begin
      d.dout = '0;
      d.dout[`DCPF_CW-1:0] = q.cfgRIdx ? q.afOff : q.aeOff;
      d.cfgRIdx = !q.cfgRIdx;
    end
    if (rdGo) begin
      d.dout = q.mem[q.rptr[`DCPF_AW-1:0]];
      d.rptr = q.rptr + 1'b1;
    end
    if (readEn && loadSelectN && !q.emptyN) begin
      ev[`DCPF_EV_UDF] = 1'b1;
    end
    if (markReq) begin
      d.mark = q.rptr;
    end
    // retransmit wins over a read advance in the same cycle
    if (retransmitReq) begin
      d.rptr = q.mark;
    end
    // resets override pointer, mark and output updates of the same cycle; enable and clear bus writes and, under partial reset, offset loads still land
    if (!masterResetN || !partialResetN) begin
      d.wptr = '0;
      d.rptr = '0;
      d.mark = '0;
      d.dout = '0;
      d.cfgWIdx = 1'b0;
      d.cfgRIdx = 1'b0;
    end
    if (!masterResetN) begin
      d.aeOff = `DCPF_AE_RST;
      d.afOff = `DCPF_AF_RST;
    end
    // flags follow the new level, so they also settle under reset
    lvl = {3'h0, d.wptr - d.rptr};
    d.emptyN = (lvl != '0);
    d.fullN = (lvl < `DCPF_DEPTH);
    d.aeN = (lvl > d.aeOff);
    d.afN = ({1'b0, lvl} + {1'b0, d.afOff}) < `DCPF_DEPTH9;
    ev[`DCPF_EV_FULL] = q.fullN && !d.fullN;
    ev[`DCPF_EV_EMPTY] = q.emptyN && !d.emptyN;
    // an event in the clearing cycle survives
    d.sts = (q.sts & ~clr) | ev;
    d.irq = |(d.sts & d.irqEn);
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= RST_S;
    end else if (clkEn) begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dataOut = q.dout;
  assign emptyFlagN = q.emptyN;
  assign fullFlagN = q.fullN;
  assign almostEmptyFlagN = q.aeN;
  assign almostFullFlagN = q.afN;
  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rresp = q.rresp;
  assign rdata = q.rdata;
  assign irq = q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic live;
  logic cfgTouch;
  logic [`DCPF_AW-1:0] wIdx;
  logic [`DCPF_DW-1:0] rdWord;
  logic [`DCPF_CW-1:0] dinLow;
  assign live = clkEn && masterResetN && partialResetN;
  assign cfgTouch = sEdge || (writeEn && !loadSelectN) || q.awready;
  assign wIdx = q.wptr[`DCPF_AW-1:0];
  assign rdWord = q.mem[q.rptr[`DCPF_AW-1:0]];
  assign dinLow = dataIn[`DCPF_CW-1:0];

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  property p_wr_mem;
    live && wrGo && inputDriveEnable |=>
      q.mem[$past(wIdx)] == $past(dataIn) && q.wptr == $past(q.wptr) + 1'b1;
  endproperty
  a_wr_mem: assert property (p_wr_mem)
    else $error("memory write lost");
  property p_wr_skip;
    live && wrGo && !inputDriveEnable |=>
      q.mem == $past(q.mem) && q.wptr == $past(q.wptr) + 1'b1;
  endproperty
  a_wr_skip: assert property (p_wr_skip)
    else $error("masked write misbehaved");
  property p_cfg_wr;
    live && writeEn && !loadSelectN && !q.cfgWIdx |=> q.aeOff == $past(dinLow);
  endproperty
  a_cfg_wr: assert property (p_cfg_wr)
    else $error("offset load lost");
  property p_mem_rd;
    live && rdGo && !retransmitReq |=>
      dataOut == $past(rdWord) && q.rptr == $past(q.rptr) + 1'b1;
  endproperty
  a_mem_rd: assert property (p_mem_rd)
    else $error("memory read wrong");
  property p_cfg_rd;
    live && readEn && !loadSelectN |=> dataOut[`DCPF_DW-1:`DCPF_CW] == '0;
  endproperty
  a_cfg_rd: assert property (p_cfg_rd)
    else $error("offset read drives high lines");
  property p_empty;
    live && rdGo && !wrGo && !retransmitReq && lvlNow == 8'h01 |=>
      !emptyFlagN;
  endproperty
  a_empty: assert property (p_empty)
    else $error("empty flag wrong");
  property p_fill;
    live && wrGo && !readEn && !retransmitReq && lvlNow == 8'h0F |=>
      !fullFlagN ##1 (fullFlagN || !clkEn || !writeEn || q.wptr != 5'h00);
  endproperty
  a_fill: assert property (p_fill)
    else $error("full flag late");
  property p_ae;
    almostEmptyFlagN == (lvlNow > q.aeOff);
  endproperty
  a_ae: assert property (p_ae)
    else $error("almost empty flag wrong");
  property p_af;
    almostFullFlagN == (({1'b0, lvlNow} + {1'b0, q.afOff}) < 9'h010);
  endproperty
  a_af: assert property (p_af)
    else $error("almost full flag wrong");

  property p_rt;
    live && retransmitReq |=> q.rptr == $past(q.mark);
  endproperty
  a_rt: assert property (p_rt)
    else $error("retransmit did not reload");

  property p_mark;
    live && markReq |=> q.mark == $past(q.rptr);
  endproperty
  a_mark: assert property (p_mark)
    else $error("mark not recorded");

  property p_mrs;
    clkEn && !masterResetN |=> q.wptr == '0 && q.rptr == '0 &&
      dataOut == '0 && q.aeOff == `DCPF_AE_RST && !emptyFlagN;
  endproperty
  a_mrs: assert property (p_mrs)
    else $error("master reset incomplete");

  property p_prs;
    clkEn && masterResetN && !partialResetN && !cfgTouch |=>
      q.wptr == '0 && dataOut == '0 && q.aeOff == $past(q.aeOff);
  endproperty
  a_prs: assert property (p_prs)
    else $error("partial reset wrong");

  property p_serial;
    live && sEdge && !(writeEn && !loadSelectN) |=>
      q.afOff[0] == $past(serialIn);
  endproperty
  a_serial: assert property (p_serial)
    else $error("serial bit not shifted");

  property p_ovf;
    live && writeEn && loadSelectN && !fullFlagN |=> q.wptr == $past(q.wptr);
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("write while full moved pointer");

  c_full: cover property (live && wrGo ##1 !fullFlagN);
  c_rt: cover property (live && retransmitReq ##1 rdGo);
  c_cfg_rd: cover property (live && readEn && !loadSelectN);
  c_irq: cover property (q.awready ##1 irq);
endmodule : dcpf_fifo_ctrl

// ===== verif/dcpf_stream_partner.sv
// writer and reader model on the fifo's streaming ports
`timescale 1ns/1ps
`include "dcpf_params.svh"
module dcpf_stream_partner (
  input wire logic mclk,
  input wire logic slow,
  output logic writeEn,
  output logic readEn,
  output logic loadSelectN,
  output logic inputDriveEnable,
  output logic [`DCPF_DW-1:0] dataIn
);
  initial begin
    writeEn = 1'h0;
    readEn = 1'h0;
    loadSelectN = 1'h1;
    inputDriveEnable = 1'h1;
    dataIn = '0;
  end
  // ----------------------------------------------------------------
  // one strobe per call
  // ----------------------------------------------------------------
  // idle data is inverted so a stale word can never pass for a write
  task automatic wr(input logic ld, input logic ie,
                    input logic [`DCPF_DW-1:0] d);
    @(posedge mclk);
    writeEn <= 1'h1;
    loadSelectN <= ld;
    inputDriveEnable <= ie;
    dataIn <= d;
    @(posedge mclk);
    writeEn <= 1'h0;
    dataIn <= ~d;
    if (slow) @(posedge mclk);
  endtask : wr
  task automatic rd(input logic ld);
    @(posedge mclk);
    readEn <= 1'h1;
    loadSelectN <= ld;
    @(posedge mclk);
    readEn <= 1'h0;
    if (slow) @(posedge mclk);
  endtask : rd
endmodule : dcpf_stream_partner

// ===== verif/tb_dcpf_fifo_ctrl.sv
// self-checking bench of the programmable fifo controller
`timescale 1ns/1ps
`include "dcpf_params.svh"
module tb_dcpf_fifo_ctrl;
  logic mclk = 1'h0, rst_n = 1'h0, slow = 1'h0, markReq = 1'h0;
  logic retransmitReq = 1'h0, masterResetN = 1'h1, partialResetN = 1'h1;
  logic serialClk = 1'h0, serialLoadEnable = 1'h0, serialIn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
  logic rready = 1'h0, awready, wready, bvalid, arready, rvalid, irq;
  logic writeEn, readEn, loadSelectN, inputDriveEnable;
  logic emptyFlagN, fullFlagN, almostEmptyFlagN, almostFullFlagN;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [1:0] bresp, rresp;
  logic [`DCPF_DW-1:0] dataIn, dataOut;
  int errorCnt = 0, nCompared = 0;
  localparam logic [15:0] SBITS = 16'h0709;
  always #2.5 mclk = ~mclk;
  // clock enable and byte strobes stay tied: gating is not under test
  dcpf_fifo_ctrl i_dcpf_fifo_ctrl (.mclk, .rst_n, .clkEn(1'h1), .writeEn,
    .loadSelectN, .inputDriveEnable, .dataIn, .readEn, .dataOut,
    .emptyFlagN, .fullFlagN, .almostEmptyFlagN, .almostFullFlagN, .markReq,
    .retransmitReq, .masterResetN, .partialResetN, .serialClk,
    .serialLoadEnable, .serialIn, .awaddr, .awvalid, .awready, .wdata,
    .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .irq);
  dcpf_stream_partner i_dcpf_stream_partner (.mclk, .slow, .writeEn,
    .readEn, .loadSelectN, .inputDriveEnable, .dataIn);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic giveVerdict();
    $display("compared %0d mismatched %0d", nCompared, errorCnt);
    if (errorCnt == 0 && nCompared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : giveVerdict
  task automatic chk(input string nm, input logic [35:0] e,
                     input logic [35:0] g);
    nCompared++;
    if (g !== e) begin
      errorCnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [35:0] wd(input logic [7:0] i);
    return {28'hC5A5A00, i};
  endfunction : wd
  // flag levels: empty, full, almost-empty, almost-full, all active low
  function automatic logic [3:0] ef(input int l, input int ae, input int af);
    return {l != 0, l != 16, l > ae, l + af < 16};
  endfunction : ef
  task automatic flg(input logic [3:0] e);
    #1;
    chk("flags", {32'h0, e}, {32'h0, emptyFlagN, fullFlagN,
        almostEmptyFlagN, almostFullFlagN});
  endtask : flg
  task automatic pop(input logic [35:0] e);
    i_dcpf_stream_partner.rd(1'h1);
    #1;
    chk("dataOut", e, dataOut);
  endtask : pop
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 40);
    bready <= 1'h0;
    if (n >= 40) begin
      $display("Error bvalid expected 1 seen 0");
      errorCnt++;
      giveVerdict();
    end else chk("bresp", {34'h0, er}, {34'h0, bresp});
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] e,
                     input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
      if (arready === 1'h1) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 40);
    rready <= 1'h0;
    if (n >= 40) begin
      $display("Error rvalid expected 1 seen 0");
      errorCnt++;
      giveVerdict();
    end else begin
      chk("rdata", {4'h0, e}, {4'h0, rdata});
      chk("rresp", {34'h0, er}, {34'h0, rresp});
    end
  endtask : axr
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'h1;
    flg(ef(0, 2, 2));
    axw(`DCPF_CLR_OFS, 32'hF, `DCPF_RESP_OKAY);
    for (int i = 0; i < 16; i++) begin
      slow = i[2];
      i_dcpf_stream_partner.wr(1'h1, 1'h1, wd(8'(i)));
      flg(ef(i + 1, 2, 2));
    end
    i_dcpf_stream_partner.wr(1'h1, 1'h1, 36'hF_FFFF_FFFF);
    flg(ef(16, 2, 2));
    axr(`DCPF_LVL_OFS, 32'h510, `DCPF_RESP_OKAY);
    axr(`DCPF_STS_OFS, 32'h5, `DCPF_RESP_OKAY);
    axr(8'h20, 32'h0, `DCPF_RESP_SLVERR);
    axw(`DCPF_STS_OFS, 32'hF, `DCPF_RESP_SLVERR);
    axw(`DCPF_EN_OFS, 32'h4, `DCPF_RESP_OKAY);
    @(posedge mclk);
    #1;
    chk("irq", 36'h1, {35'h0, irq});
    axw(`DCPF_CLR_OFS, 32'h4, `DCPF_RESP_OKAY);
    @(posedge mclk);
    #1;
    chk("irq", 36'h0, {35'h0, irq});
    @(posedge mclk);
    markReq <= 1'h1;
    @(posedge mclk);
    markReq <= 1'h0;
    for (int i = 0; i < 3; i++) pop(wd(8'(i)));
    @(posedge mclk);
    retransmitReq <= 1'h1;
    @(posedge mclk);
    retransmitReq <= 1'h0;
    for (int i = 0; i < 16; i++) pop(wd(8'(i)));
    flg(ef(0, 2, 2));
    pop(wd(8'hF));
    axr(`DCPF_STS_OFS, 32'hB, `DCPF_RESP_OKAY);
    // a skipped slot keeps what the previous lap left there
    i_dcpf_stream_partner.wr(1'h1, 1'h1, wd(8'h40));
    i_dcpf_stream_partner.wr(1'h1, 1'h0, wd(8'h41));
    i_dcpf_stream_partner.wr(1'h1, 1'h1, wd(8'h42));
    flg(ef(3, 2, 2));
    pop(wd(8'h40));
    pop(wd(8'h1));
    pop(wd(8'h42));
    i_dcpf_stream_partner.wr(1'h0, 1'h1, 36'hF_FFFF_FF05);
    i_dcpf_stream_partner.wr(1'h0, 1'h1, 36'hF_FFFF_FF03);
    i_dcpf_stream_partner.rd(1'h0);
    #1 chk("dataOut", 36'h5, dataOut);
    i_dcpf_stream_partner.rd(1'h0);
    #1 chk("dataOut", 36'h3, dataOut);
    for (int i = 0; i < 3; i++) i_dcpf_stream_partner.wr(1'h1, 1'h1, wd(8'h50));
    flg(ef(3, 5, 3));
    @(posedge mclk);
    partialResetN <= 1'h0;
    @(posedge mclk);
    partialResetN <= 1'h1;
    #1 chk("dataOut", 36'h0, dataOut);
    flg(ef(0, 5, 3));
    axr(`DCPF_AF_OFS, 32'h3, `DCPF_RESP_OKAY);
    i_dcpf_stream_partner.wr(1'h1, 1'h1, wd(8'h60));
    pop(wd(8'h60));
    i_dcpf_stream_partner.wr(1'h1, 1'h1, wd(8'h61));
    @(posedge mclk);
    masterResetN <= 1'h0;
    @(posedge mclk);
    masterResetN <= 1'h1;
    #1 chk("dataOut", 36'h0, dataOut);
    flg(ef(0, 2, 2));
    axr(`DCPF_AE_OFS, 32'h2, `DCPF_RESP_OKAY);
    serialLoadEnable <= 1'h1;
    for (int b = 15; b >= 0; b--) begin
      @(posedge mclk);
      serialClk <= 1'h0;
      serialIn <= SBITS[b];
      @(posedge mclk);
      serialClk <= 1'h1;
    end
    @(posedge mclk);
    serialLoadEnable <= 1'h0;
    serialClk <= 1'h0;
    axr(`DCPF_AE_OFS, 32'h7, `DCPF_RESP_OKAY);
    axr(`DCPF_AF_OFS, 32'h9, `DCPF_RESP_OKAY);
    axw(`DCPF_AF_OFS, 32'h10, `DCPF_RESP_OKAY);
    flg(ef(0, 7, 16));
    axr(`DCPF_AF_OFS, 32'h10, `DCPF_RESP_OKAY);
    axr(`DCPF_EN_OFS, 32'h4, `DCPF_RESP_OKAY);
    axr(`DCPF_CLR_OFS, 32'h0, `DCPF_RESP_OKAY);
    giveVerdict();
  end
endmodule : tb_dcpf_fifo_ctrl
